/* anim_seq_cfg_regs.sv */
// Functional notes
// - Sequencer 1 holds four 2-bit slot patterns
// - Sequencer 2 holds four 2-bit slot patterns
// - Sequencer 3 holds four 2-bit slot patterns
// - Sequencer 1 slot enables in bits 7..4
// - Sequencer 0 slot enables in bits 3..0
// - Sequencer 3 slot enables in bits 7..4
// - Sequencer 2 slot enables in bits 3..0
// - All registers reset to zero, read/write
// - Sequencer 0 patterns sit one register below
// - Each output picks a sequencer by 2 bits
// - Repeat count: 0..2 repeats, 3 endless
`default_nettype none
module anim_seq_cfg_regs
  import anim_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                                      core_clk_i,
  input  wire logic                                      arst_n_i,
  // Register port from the serial interface logic
  input  wire logic                                      wr_en_i,
  input  wire logic                                      rd_en_i,
  input  wire logic [anim_cfg_pkg::ADDR_W-1:0]           addr_i,
  input  wire logic [anim_cfg_pkg::DATA_W-1:0]           wdata_i,
  output logic      [anim_cfg_pkg::DATA_W-1:0]           rdata_o,
  output logic                                           rvalid_o,
  // Engine control
  input  wire logic                                      start_i,
  input  wire logic                                      stop_i,
  input  wire logic [anim_cfg_pkg::NUM_SEQ-1:0]          step_i,
  // Engine state and configuration out
  output logic      [anim_cfg_pkg::NUM_SEQ-1:0]          seq_running_o,
  output logic      [anim_cfg_pkg::NUM_SEQ-1:0][1:0]     seq_slot_o,
  output logic      [anim_cfg_pkg::NUM_SEQ-1:0][1:0]     seq_pattern_o,
  output logic      [7:0]                                out_seq_sel_o
);
  import anim_cfg_pkg::*;

  logic [NUM_REGS-1:0][DATA_W-1:0] regs_reg;   // Register bank, index = offset - first
  seq_cfg_if                       cfg_bus();  // Fields toward the walker

  // Offset inside the bank, or out of range
  function automatic logic in_bank(input logic [ADDR_W-1:0] a);
    return (a >= FIRST_ADDR) && (a <= LAST_ADDR);
  endfunction : in_bank

  function automatic logic [2:0] bank_idx(input logic [ADDR_W-1:0] a);
    return 3'(a - FIRST_ADDR);
  endfunction : bank_idx

  // Register writes; unmapped writes are dropped
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= REG_RESET;
      end
    end else if (wr_en_i && in_bank(addr_i)) begin
      regs_reg[bank_idx(addr_i)] <= wdata_i;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o  <= REG_RESET;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= in_bank(addr_i) ? regs_reg[bank_idx(addr_i)] : UNMAPPED_DATA;
      end
    end
  end

  assign out_seq_sel_o = regs_reg[bank_idx(OUT_MAP_ADDR)];

  // Field unpacking toward the walker
  // sequencer 0 to 3 patterns
  assign cfg_bus.slot_pat[0] = regs_reg[bank_idx(SEQ0_PAT_ADDR)];
  assign cfg_bus.slot_pat[1] = regs_reg[bank_idx(SEQ1_PAT_ADDR)];
  assign cfg_bus.slot_pat[2] = regs_reg[bank_idx(SEQ2_PAT_ADDR)];
  assign cfg_bus.slot_pat[3] = regs_reg[bank_idx(SEQ3_PAT_ADDR)];
  assign cfg_bus.slot_en[0]  = regs_reg[bank_idx(SEQ01_EN_ADDR)][EN_LO_LSB +: NUM_SLOTS];
  assign cfg_bus.slot_en[1]  = regs_reg[bank_idx(SEQ01_EN_ADDR)][EN_HI_LSB +: NUM_SLOTS];
  assign cfg_bus.slot_en[2]  = regs_reg[bank_idx(SEQ23_EN_ADDR)][EN_LO_LSB +: NUM_SLOTS];
  assign cfg_bus.slot_en[3]  = regs_reg[bank_idx(SEQ23_EN_ADDR)][EN_HI_LSB +: NUM_SLOTS];
  assign cfg_bus.repeat_cnt  = regs_reg[bank_idx(REPEAT_ADDR)];

  // Slot walker for all four sequencers
  seq_slot_walker u_walker (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .cfg        (cfg_bus),
    .start_i    (start_i),
    .stop_i     (stop_i),
    .step_i     (step_i),
    .running_o  (seq_running_o),
    .slot_o     (seq_slot_o),
    .pattern_o  (seq_pattern_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Register checks
  chk_write_readback: assert property (
    (wr_en_i && in_bank(addr_i)) ##1 (rd_en_i && addr_i == $past(addr_i) && !wr_en_i)
      |=> (rvalid_o && rdata_o == $past(wdata_i, 2)))
    else $error("readback differs from written byte");
  chk_unmapped_zero: assert property (
    (rd_en_i && !in_bank(addr_i)) |=> (rvalid_o && rdata_o == UNMAPPED_DATA))
    else $error("unmapped read not zero");
  chk_rvalid_pulse: assert property (
    !rd_en_i |=> !rvalid_o)
    else $error("read answer without a request");
  chk_seq1_field: assert property (
    (wr_en_i && addr_i == SEQ1_PAT_ADDR) |=> cfg_bus.slot_pat[1][7:6] == $past(wdata_i[7:6]))
    else $error("sequencer 1 slot 3 field wrong");
  chk_seq23_enables: assert property (
    (wr_en_i && addr_i == SEQ23_EN_ADDR) |=> (cfg_bus.slot_en[3] == $past(wdata_i[7:4]) &&
                                              cfg_bus.slot_en[2] == $past(wdata_i[3:0])))
    else $error("sequencer 2/3 enable split wrong");
  chk_seq01_enables: assert property (
    (wr_en_i && addr_i == SEQ01_EN_ADDR) |=> (cfg_bus.slot_en[1] == $past(wdata_i[7:4]) &&
                                              cfg_bus.slot_en[0] == $past(wdata_i[3:0])))
    else $error("sequencer 0/1 enable split wrong");
  chk_sel_map: assert property (
    (wr_en_i && addr_i == OUT_MAP_ADDR) |=> out_seq_sel_o == $past(wdata_i))
    else $error("output select not updated");

  // Main scenarios
  cov_write_all: cover property (wr_en_i && addr_i == REPEAT_ADDR && wdata_i == 8'hFF);
  cov_run: cover property (start_i ##1 (seq_running_o != 4'h0));
  cov_stop: cover property ((seq_running_o != 4'h0) ##1 stop_i);

endmodule : anim_seq_cfg_regs
`default_nettype wire

/* anim_cfg_pkg.sv */
`default_nettype none
package anim_cfg_pkg;
  // Register port widths
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  // Register offsets
  localparam logic [7:0]  OUT_MAP_ADDR   = 8'h05;  // Output-to-sequencer mapping
  localparam logic [7:0]  SEQ0_PAT_ADDR  = 8'h06;  // seq0_slot_patterns
  localparam logic [7:0]  SEQ1_PAT_ADDR  = 8'h07;  // seq1_slot_patterns
  localparam logic [7:0]  SEQ2_PAT_ADDR  = 8'h08;  // seq2_slot_patterns
  localparam logic [7:0]  SEQ3_PAT_ADDR  = 8'h09;  // seq3_slot_patterns
  localparam logic [7:0]  SEQ01_EN_ADDR  = 8'h0A;  // seq01_slot_enables
  localparam logic [7:0]  SEQ23_EN_ADDR  = 8'h0B;  // seq23_slot_enables
  localparam logic [7:0]  REPEAT_ADDR    = 8'h0C;  // seq_repeat_counts
  localparam logic [7:0]  FIRST_ADDR     = 8'h05;  // Lowest mapped offset
  localparam logic [7:0]  LAST_ADDR      = 8'h0C;  // Highest mapped offset
  localparam int unsigned NUM_REGS       = 8;
  localparam logic [7:0]  REG_RESET      = 8'h00;  // Reset value of every register
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;  // Read answer outside the bank
  // Sequencer shape
  localparam int unsigned NUM_SEQ        = 4;
  localparam int unsigned NUM_SLOTS      = 4;
  localparam int unsigned SLOT_W         = 2;      // Slot index and pattern field width
  localparam int unsigned EN_LO_LSB      = 0;      // Even sequencer enables start here
  localparam int unsigned EN_HI_LSB      = 4;      // Odd sequencer enables start here
  localparam logic [1:0]  REPEAT_FOREVER = 2'h3;   // Repeat code meaning no end
  // Slot walker states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } walk_state_t;
endpackage : anim_cfg_pkg
`default_nettype wire

/* seq_cfg_if.sv */
`default_nettype none
// Configuration handed from the register bank to the slot walker
interface seq_cfg_if;
  import anim_cfg_pkg::*;
  logic [NUM_SEQ-1:0][7:0]           slot_pat;    // Four 2-bit pattern fields per sequencer
  logic [NUM_SEQ-1:0][NUM_SLOTS-1:0] slot_en;     // One enable per slot
  logic [NUM_SEQ-1:0][1:0]           repeat_cnt;  // Repeat code per sequencer
  modport prod (output slot_pat, output slot_en, output repeat_cnt);
  modport cons (input slot_pat, input slot_en, input repeat_cnt);
endinterface : seq_cfg_if
`default_nettype wire

/* seq_slot_walker.sv */
`default_nettype none
// Steps each sequencer through its enabled slots
module seq_slot_walker
  import anim_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  // Configuration
  seq_cfg_if.cons                          cfg,
  // Engine control
  input  wire logic                        start_i,
  input  wire logic                        stop_i,
  input  wire logic [NUM_SEQ-1:0]          step_i,
  // Sequencer state
  output logic      [NUM_SEQ-1:0]          running_o,
  output logic      [NUM_SEQ-1:0][SLOT_W-1:0] slot_o,
  output logic      [NUM_SEQ-1:0][SLOT_W-1:0] pattern_o
);
  import anim_cfg_pkg::*;

  // First enabled slot at or above a starting index; bit 2 flags a hit
  function automatic logic [2:0] find_slot(input logic [NUM_SLOTS-1:0] en, input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction : find_slot

  // Pattern field of one slot
  function automatic logic [1:0] pat_of(input logic [7:0] pat, input logic [1:0] idx);
    return pat[idx*SLOT_W +: SLOT_W];
  endfunction : pat_of

  for (genvar s = 0; s < NUM_SEQ; s++) begin : g_seq
    walk_state_t state_reg;        // Idle or running
    logic [1:0]  reps_reg;         // Repeats already played
    logic [2:0]  nxt_hit;          // Next enabled slot above the current one
    logic [2:0]  first_hit;        // Lowest enabled slot
    assign nxt_hit   = find_slot(cfg.slot_en[s], {1'b0, slot_o[s]} + 3'h1);
    assign first_hit = find_slot(cfg.slot_en[s], 3'h0);
    assign running_o[s] = (state_reg == ST_RUN);

    // Slot walk: ascending, skipping disabled slots, repeating as told
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        state_reg    <= ST_IDLE;
        reps_reg     <= 2'h0;
        slot_o[s]    <= 2'h0;
        pattern_o[s] <= 2'h0;
      end else if (stop_i) begin
        // Stop wins over everything
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (start_i && first_hit[2]) begin
              state_reg    <= ST_RUN;
              reps_reg     <= 2'h0;
              slot_o[s]    <= first_hit[1:0];
              pattern_o[s] <= pat_of(cfg.slot_pat[s], first_hit[1:0]);
            end
          end
          ST_RUN: begin
            if (step_i[s]) begin
              if (nxt_hit[2]) begin
                slot_o[s]    <= nxt_hit[1:0];
                pattern_o[s] <= pat_of(cfg.slot_pat[s], nxt_hit[1:0]);
              end else if (first_hit[2] && ((cfg.repeat_cnt[s] == REPEAT_FOREVER) ||
                                            (reps_reg < cfg.repeat_cnt[s]))) begin
                reps_reg     <= (reps_reg == REPEAT_FOREVER) ? reps_reg : reps_reg + 2'h1;
                slot_o[s]    <= first_hit[1:0];
                pattern_o[s] <= pat_of(cfg.slot_pat[s], first_hit[1:0]);
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end

    // Checks on the walk
    chk_slot_enabled: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(running_o[s]) |-> cfg.slot_en[s][slot_o[s]])
      else $error("walker started on a disabled slot");
    chk_slot_ascend: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (running_o[s] && step_i[s] && !stop_i && nxt_hit[2]) |=> (slot_o[s] > $past(slot_o[s])))
      else $error("walker did not move up");
    chk_once_stops: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (running_o[s] && step_i[s] && !nxt_hit[2] && cfg.repeat_cnt[s] == 2'h0) |=> !running_o[s])
      else $error("walker kept running with no repeats");
    chk_forever_runs: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (running_o[s] && !stop_i && cfg.repeat_cnt[s] == REPEAT_FOREVER && first_hit[2]) |=> running_o[s])
      else $error("endless repeat ended");
    chk_stop_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      stop_i |=> !running_o[s])
      else $error("stop did not idle the walker");
    cov_wrap: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
      running_o[s] && step_i[s] && !nxt_hit[2] && first_hit[2] && cfg.repeat_cnt[s] != 2'h0);
  end

endmodule : seq_slot_walker
`default_nettype wire

/* host_port_model.sv */
`default_nettype none
// Host side of the byte register port, one strobe per byte
module host_port_model (
  // Clock
  input  wire logic       core_clk_i,
  // Register port towards the bank
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // Byte write held for one edge, then the idle bus is scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : wr
  // Byte read; the answer stands for one cycle after the strobe edge, so take it then
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk_i);
    addr_o  = a;
    rd_en_o = 1'b1;
    @(negedge core_clk_i);
    ok = (rvalid_i === 1'b1);
    d  = rdata_i;
    rd_en_o = 1'b0;
    addr_o  = ~a;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

/* anim_seq_cfg_regs_bench.sv */
`default_nettype none
// Register bank and slot walker bench
module anim_seq_cfg_regs_bench;
  import anim_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk_i = 1'b0;  // 200 MHz clock
  logic            arst_n_i   = 1'b0;  // Reset held at start
  logic            wr_en, rd_en, rvalid, start, stop;
  logic [7:0]      addr, wdata, rdata, out_sel;
  logic [3:0]      step, running;
  logic [3:0][1:0] slot, pat;
  int              n_fail    = 0;      // Mismatches
  int              cmp_count = 0;      // Comparisons
  // Clock toggles every half period
  always #2.5 core_clk_i = ~core_clk_i;
  host_port_model u_host_port_model (.core_clk_i(core_clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  anim_seq_cfg_regs u_anim_seq_cfg_regs (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .start_i(start),
    .stop_i(stop), .step_i(step), .seq_running_o(running), .seq_slot_o(slot), .seq_pattern_o(pat),
    .out_seq_sel_o(out_sel));
  // One comparison, reported at once on mismatch
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Read a register and compare the answer
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host_port_model.rd(a, d, ok);
    check("read strobe answer", 8'h01, {7'h00, ok});
    check("read data", exp, d);
  endtask : rd_chk
  // One-edge engine command, outputs settled on return
  task automatic pulse(input logic go, input logic halt, input logic [3:0] st);
    @(negedge core_clk_i);
    start = go;
    stop  = halt;
    step  = st;
    @(negedge core_clk_i);
    start = 1'b0;
    stop  = 1'b0;
    step  = 4'h0;
  endtask : pulse
  // Engine state against expected running, slots and patterns
  task automatic eng_chk(input logic [3:0] r, input logic [7:0] s, input logic [7:0] p, input logic [7:0] pm);
    check("running", {4'h0, r}, {4'h0, running});
    check("slots", s, slot);
    check("patterns", p & pm, pat & pm);
  endtask : eng_chk
  // Offsets 0x05 to 0x0C read zero after reset, unmapped 0x0D too
  task automatic t_reset();
    for (int a = 5; a <= 13; a++) rd_chk(8'(a), 8'h00);
  endtask : t_reset
  // Write distinct values, read them back, unmapped write ignored
  task automatic t_rw();
    logic [7:0] ad [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    logic [7:0] vl [8] = '{8'hC6, 8'h1B, 8'hE4, 8'h20, 8'h40, 8'hA5, 8'h84, 8'h04};
    for (int i = 0; i < 8; i++) u_host_port_model.wr(ad[i], vl[i]);
    u_host_port_model.wr(8'h0D, 8'h5A);
    for (int i = 0; i < 8; i++) rd_chk(ad[i], vl[i]);
    rd_chk(8'h0D, 8'h00);
    check("output select", 8'hC6, out_sel);
  endtask : t_rw
  // All four sequencers walk their enabled slots with their patterns
  task automatic t_walk();
    pulse(1'b1, 1'b0, 4'h0);
    eng_chk(4'hF, 8'hE4, 8'h67, 8'hFF);
    pulse(1'b0, 1'b0, 4'hF);
    eng_chk(4'h3, 8'hEE, 8'h0D, 8'h0F);
    pulse(1'b0, 1'b0, 4'h2);
    eng_chk(4'h3, 8'hE6, 8'h05, 8'h0F);
    pulse(1'b0, 1'b0, 4'h2);
    eng_chk(4'h3, 8'hEE, 8'h0D, 8'h0F);
    pulse(1'b0, 1'b0, 4'h2);
    eng_chk(4'h1, 8'hEE, 8'h0D, 8'h0F);
    pulse(1'b0, 1'b1, 4'h0);
    eng_chk(4'h0, 8'hEE, 8'h6D, 8'hFF);
  endtask : t_walk
  // No enabled slot: start and step change nothing
  task automatic t_refuse();
    u_host_port_model.wr(8'h0A, 8'h00);
    u_host_port_model.wr(8'h0B, 8'h00);
    pulse(1'b1, 1'b0, 4'hF);
    eng_chk(4'h0, 8'hEE, 8'h6D, 8'hFF);
  endtask : t_refuse
  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    start = 1'b0;
    stop  = 1'b0;
    step  = 4'h0;
    repeat (3) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    t_reset();
    t_rw();
    t_walk();
    t_refuse();
    summarize();
  end
endmodule : anim_seq_cfg_regs_bench
`default_nettype wire
